// ==== rtl/adc_serial_port.sv ====
// What this block does
// - Sync pin low 2048 clocks resets device
// - Low 2 to 2047 clocks means synchronize
// - Sync pin sampled on master clock rise
// - Input bit captured on serial clock fall
// - Next output bit shifted after clock rise
// - Output driven only while select is low
// - First ready edge after power-on time
// - Register defaults ready after acquisition time
// - Serial mode is clock idle low, trailing capture
`include "adc_port_map.svh"

module adc_serial_port import adc_port_pkg::*; #(
	parameter int unsigned WORD_BITS = `WORD_BITS_DEF,
	parameter int unsigned POR_CYCLES = `POR_CYCLES_DEF,
	parameter int unsigned REGACQ_CYCLES = `REGACQ_CYCLES_DEF,
	parameter int unsigned TIMEOUT_CYCLES = `SPI_TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire logic sync_reset_n,
	input wire logic conv_done,
	input wire logic tx_load,
	input wire logic [WORD_BITS-1:0] tx_data,
	output logic [WORD_BITS-1:0] rx_data,
	output logic rx_valid,
	output logic sync_pulse,
	output logic device_reset,
	output logic por_done,
	output logic regs_ready,
	output logic conversion_ready_strobe
);
	localparam int unsigned PW = $clog2(POR_CYCLES + 1);
	localparam int unsigned TW = $clog2(TIMEOUT_CYCLES);
	localparam logic [PW-1:0] POR_LAST = PW'(POR_CYCLES);
	localparam logic [PW-1:0] REGACQ_LAST = PW'(REGACQ_CYCLES);
	localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_CYCLES - 1);

	link_word_if #(.WORD_BITS(WORD_BITS)) link ();

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [3:0] raw, s1_ff, s2_ff, s3_ff, flt_ff, nxt_flt, fltp_ff;

	assign raw = {link.rx_tgl, sync_reset_n, sclk, cs_n};
	assign nxt_flt = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & flt_ff);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s1_ff <= `SYNC_INIT;
			s2_ff <= `SYNC_INIT;
			s3_ff <= `SYNC_INIT;
			flt_ff <= `SYNC_INIT;
			fltp_ff <= `SYNC_INIT;
		end else begin
			s1_ff <= raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			flt_ff <= nxt_flt;
			fltp_ff <= flt_ff;
			if (link.core_rst) begin // No false word edge after reset
				s1_ff[`PIN_TGL] <= 1'b0;
				s2_ff[`PIN_TGL] <= 1'b0;
				s3_ff[`PIN_TGL] <= 1'b0;
				flt_ff[`PIN_TGL] <= 1'b0;
				fltp_ff[`PIN_TGL] <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Sync and reset pulse measurement
	// ****************************************************************
	logic [11:0] low_cnt_ff, nxt_low_cnt;
	logic core_rst_ff, nxt_core_rst, sync_ff, nxt_sync;

	always_comb begin
		nxt_low_cnt = 12'h0000;
		nxt_sync = 1'b0;
		nxt_core_rst = 1'b0;
		if (!flt_ff[`PIN_SYNC]) begin
			if (low_cnt_ff == `SYNC_RESET_CYCLES) begin
				nxt_low_cnt = low_cnt_ff;
			end else begin
				nxt_low_cnt = low_cnt_ff + 12'h0001;
			end
			nxt_core_rst = (low_cnt_ff >= `SYNC_MAX_CYCLES);
		end else if (low_cnt_ff != 12'h0000 && low_cnt_ff <= `SYNC_MAX_CYCLES) begin
			nxt_sync = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			low_cnt_ff <= 12'h0000;
			core_rst_ff <= 1'b1;
			sync_ff <= 1'b0;
		end else begin
			low_cnt_ff <= nxt_low_cnt;
			core_rst_ff <= nxt_core_rst;
			sync_ff <= nxt_sync;
		end
	end

	assign link.core_rst = core_rst_ff;

	// ****************************************************************
	// Power-on and register default timing
	// ****************************************************************
	logic [PW-1:0] por_cnt_ff, nxt_por_cnt;
	logic por_ff, nxt_por, regs_ff, nxt_regs, por_evt;

	always_comb begin
		nxt_por_cnt = (por_cnt_ff == POR_LAST) ? por_cnt_ff : por_cnt_ff + 1'b1;
		nxt_por = (nxt_por_cnt == POR_LAST);
		nxt_regs = regs_ff | (nxt_por_cnt >= REGACQ_LAST);
		por_evt = nxt_por & ~por_ff;
	end

	always_ff @(posedge clk) begin
		if (core_rst_ff) begin
			por_cnt_ff <= '0;
			por_ff <= 1'b0;
			regs_ff <= 1'b0;
		end else begin
			por_cnt_ff <= nxt_por_cnt;
			por_ff <= nxt_por;
			regs_ff <= nxt_regs;
		end
	end

	// ****************************************************************
	// Conversion ready strobe
	// ****************************************************************
	strobe_state_t state_ff, nxt_state;
	logic [2:0] scnt_ff, nxt_scnt;
	logic pend_ff, nxt_pend, strobe_ff, nxt_strobe, take;

	always_comb begin
		nxt_state = state_ff;
		nxt_scnt = scnt_ff + 3'h1;
		take = 1'b0;
		case (state_ff)
			STB_IDLE: begin
				nxt_scnt = 3'h0;
				if (pend_ff) begin
					nxt_state = STB_HIGH;
					take = 1'b1;
				end
			end
			STB_HIGH: begin
				if (scnt_ff == `STROBE_LAST_CYCLE) begin
					nxt_state = STB_LOW;
					nxt_scnt = 3'h0;
				end
			end
			STB_LOW: begin
				if (scnt_ff == `STROBE_LAST_CYCLE) begin
					nxt_state = STB_IDLE;
					nxt_scnt = 3'h0;
				end
			end
			default: begin
				nxt_state = STB_IDLE;
				nxt_scnt = 3'h0;
			end
		endcase
		// New event wins over the clear
		nxt_pend = por_evt | (conv_done & por_ff) | (pend_ff & ~take);
		nxt_strobe = (nxt_state == STB_HIGH);
	end

	always_ff @(posedge clk) begin
		if (core_rst_ff) begin
			state_ff <= STB_IDLE;
			scnt_ff <= 3'h0;
			pend_ff <= 1'b0;
			strobe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			scnt_ff <= nxt_scnt;
			pend_ff <= nxt_pend;
			strobe_ff <= nxt_strobe;
		end
	end

	// ****************************************************************
	// Frame watchdog, word hand-over
	// ****************************************************************
	logic [TW-1:0] idle_cnt_ff, nxt_idle_cnt;
	logic abort_ff, nxt_abort, activity, rx_valid_ff, nxt_rx_valid;
	logic [WORD_BITS-1:0] rx_data_ff, nxt_rx_data, tx_hold_ff, nxt_tx_hold;

	assign activity = (flt_ff[`PIN_SCLK] != fltp_ff[`PIN_SCLK]) |
		(flt_ff[`PIN_TGL] != fltp_ff[`PIN_TGL]);

	always_comb begin
		nxt_abort = 1'b0;
		nxt_idle_cnt = idle_cnt_ff + 1'b1;
		if (flt_ff[`PIN_CS] || activity) begin
			nxt_idle_cnt = '0;
		end else if (idle_cnt_ff == TIMEOUT_LAST) begin
			nxt_idle_cnt = '0;
			nxt_abort = 1'b1;
		end
		nxt_rx_valid = (flt_ff[`PIN_TGL] != fltp_ff[`PIN_TGL]);
		nxt_rx_data = nxt_rx_valid ? link.rx_word : rx_data_ff;
		nxt_tx_hold = (tx_load && flt_ff[`PIN_CS]) ? tx_data : tx_hold_ff;
	end

	always_ff @(posedge clk) begin
		if (core_rst_ff) begin
			idle_cnt_ff <= '0;
			abort_ff <= 1'b0;
			rx_valid_ff <= 1'b0;
			rx_data_ff <= '0;
			tx_hold_ff <= '0;
		end else begin
			idle_cnt_ff <= nxt_idle_cnt;
			abort_ff <= nxt_abort;
			rx_valid_ff <= nxt_rx_valid;
			rx_data_ff <= nxt_rx_data;
			tx_hold_ff <= nxt_tx_hold;
		end
	end

	assign link.abort = abort_ff;
	assign link.tx_word = tx_hold_ff;

	spi_shift_engine #(.WORD_BITS(WORD_BITS)) u_shift (
		.sclk(sclk),
		.cs_n(cs_n),
		.sdi(sdi),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.link(link)
	);

	assign rx_data = rx_data_ff;
	assign rx_valid = rx_valid_ff;
	assign sync_pulse = sync_ff;
	assign device_reset = core_rst_ff;
	assign por_done = por_ff;
	assign regs_ready = regs_ff;
	assign conversion_ready_strobe = strobe_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_long_low_reset: assert property (@(posedge clk) disable iff (!resetn)
		(!flt_ff[`PIN_SYNC] && low_cnt_ff == `SYNC_MAX_CYCLES) |=> device_reset)
		else $error("long sync low did not reset");
	a_short_low_sync: assert property (@(posedge clk) disable iff (!resetn)
		(flt_ff[`PIN_SYNC] && low_cnt_ff != 12'h0000 && low_cnt_ff <= `SYNC_MAX_CYCLES)
		|=> sync_pulse && !device_reset)
		else $error("short sync low not seen as sync");
	a_no_sync_reset: assert property (@(posedge clk) disable iff (!resetn)
		sync_pulse |-> $past(low_cnt_ff) != `SYNC_RESET_CYCLES)
		else $error("reset pulse taken as sync");
	a_sync_sampled: assert property (@(posedge clk) disable iff (!resetn)
		$changed(flt_ff[`PIN_SYNC]) |-> $past(s2_ff[`PIN_SYNC]) == $past(s3_ff[`PIN_SYNC]))
		else $error("sync level changed without agreement");
	a_strobe_shape: assert property (@(posedge clk) disable iff (core_rst_ff)
		$rose(conversion_ready_strobe) |-> conversion_ready_strobe[*4] ##1 !conversion_ready_strobe[*4])
		else $error("ready strobe not four high four low");
	a_first_strobe: assert property (@(posedge clk) disable iff (core_rst_ff)
		$rose(por_done) |-> ##[0:3] conversion_ready_strobe)
		else $error("no ready strobe after power-on");
	a_strobe_after_por: assert property (@(posedge clk) disable iff (core_rst_ff)
		conversion_ready_strobe |-> por_done)
		else $error("ready strobe before power-on done");
	a_regs_time: assert property (@(posedge clk) disable iff (core_rst_ff)
		regs_ready |-> (por_cnt_ff >= REGACQ_LAST))
		else $error("register defaults ready too early");
	a_timeout_abort: assert property (@(posedge clk) disable iff (core_rst_ff)
		(!flt_ff[`PIN_CS] && !activity && idle_cnt_ff == TIMEOUT_LAST) |=> link.abort ##1 !link.abort)
		else $error("idle frame not abandoned");
	c_device_reset: cover property (@(posedge clk) disable iff (!resetn) $rose(device_reset));
	c_sync: cover property (@(posedge clk) disable iff (!resetn) sync_pulse);
	c_rx_word: cover property (@(posedge clk) disable iff (core_rst_ff) rx_valid);
	c_strobe: cover property (@(posedge clk) disable iff (core_rst_ff) $rose(conversion_ready_strobe));
endmodule : adc_serial_port

// ==== rtl/adc_port_map.svh ====
`ifndef ADC_PORT_MAP_SVH
`define ADC_PORT_MAP_SVH

// ****************************************************************
// Timing figures
// ****************************************************************
`define CLK_PERIOD_NS 32'h0000_0032
`define NS_PER_US 32'h0000_03e8
`define TPOR_US 32'h0000_00fa
`define TREGACQ_US 32'h0000_0005
`define POR_CYCLES_DEF ((`TPOR_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REGACQ_CYCLES_DEF ((`TREGACQ_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_RESET_CYCLES 12'h0800
`define SYNC_MAX_CYCLES 12'h07ff
`define SPI_TIMEOUT_CYCLES 32'h0000_8000
`define STROBE_LAST_CYCLE 3'h3
`define WORD_BITS_DEF 32'h0000_0018

// ****************************************************************
// Synchroniser bit positions and reset levels
// ****************************************************************
`define PIN_CS 2'h0
`define PIN_SCLK 2'h1
`define PIN_SYNC 2'h2
`define PIN_TGL 2'h3
`define SYNC_INIT 4'h5

`endif

// ==== rtl/adc_port_pkg.sv ====
package adc_port_pkg;
	typedef enum logic [1:0] {
		STB_IDLE = 2'b00,
		STB_HIGH = 2'b01,
		STB_LOW = 2'b10
	} strobe_state_t;
endpackage : adc_port_pkg

// ==== rtl/link_word_if.sv ====
interface link_word_if #(parameter int unsigned WORD_BITS = 24) ();
	logic [WORD_BITS-1:0] rx_word;
	logic [WORD_BITS-1:0] tx_word;
	logic rx_tgl;
	logic abort;
	logic core_rst;
	modport link_side (output rx_word, output rx_tgl, input tx_word, input abort, input core_rst);
	modport core_side (input rx_word, input rx_tgl, output tx_word, output abort, output core_rst);
endinterface : link_word_if

// ==== rtl/spi_shift_engine.sv ====
`include "adc_port_map.svh"

module spi_shift_engine import adc_port_pkg::*; #(
	parameter int unsigned WORD_BITS = 24
) (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	link_word_if.link_side link
);
	localparam int unsigned CW = $clog2(WORD_BITS);
	localparam logic [CW-1:0] LAST = CW'(WORD_BITS - 1);

	logic frame_clr;
	logic [CW-1:0] rcnt_ff, nxt_rcnt, tcnt_ff, nxt_tcnt;
	logic [WORD_BITS-1:0] rsr_ff, nxt_rsr, rword_ff, nxt_rword, tsr_ff, nxt_tsr;
	logic tgl_ff, nxt_tgl, sdo_ff, nxt_sdo;

	// Frame deselect or timeout clears the bit engine
	assign frame_clr = cs_n | link.abort;

	// ****************************************************************
	// Receive on falling edge
	// ****************************************************************
	always_comb begin
		nxt_rsr = {rsr_ff[WORD_BITS-2:0], sdi};
		nxt_rcnt = (rcnt_ff == LAST) ? '0 : rcnt_ff + 1'b1;
		nxt_rword = rword_ff;
		nxt_tgl = tgl_ff;
		if (rcnt_ff == LAST) begin
			nxt_rword = nxt_rsr;
			nxt_tgl = ~tgl_ff;
		end
	end

	always_ff @(negedge sclk or posedge frame_clr) begin
		if (frame_clr) begin
			rcnt_ff <= '0;
			rsr_ff <= '0;
		end else begin
			rcnt_ff <= nxt_rcnt;
			rsr_ff <= nxt_rsr;
		end
	end

	always_ff @(negedge sclk or posedge link.core_rst) begin
		if (link.core_rst) begin
			rword_ff <= '0;
			tgl_ff <= 1'b0;
		end else begin
			rword_ff <= nxt_rword;
			tgl_ff <= nxt_tgl;
		end
	end

	// ****************************************************************
	// Transmit on rising edge
	// ****************************************************************
	always_comb begin
		nxt_tcnt = (tcnt_ff == LAST) ? '0 : tcnt_ff + 1'b1;
		if (tcnt_ff == '0) begin
			nxt_sdo = link.tx_word[WORD_BITS-1];
			nxt_tsr = {link.tx_word[WORD_BITS-2:0], 1'b0};
		end else begin
			nxt_sdo = tsr_ff[WORD_BITS-1];
			nxt_tsr = {tsr_ff[WORD_BITS-2:0], 1'b0};
		end
	end

	always_ff @(posedge sclk or posedge frame_clr) begin
		if (frame_clr) begin
			tcnt_ff <= '0;
			tsr_ff <= '0;
			sdo_ff <= 1'b0;
		end else begin
			tcnt_ff <= nxt_tcnt;
			tsr_ff <= nxt_tsr;
			sdo_ff <= nxt_sdo;
		end
	end

	assign sdo = sdo_ff;
	assign sdo_oe = ~cs_n;
	assign link.rx_word = rword_ff;
	assign link.rx_tgl = tgl_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_sdo_msb_first: assert property (@(posedge sclk) disable iff (frame_clr)
		(tcnt_ff == '0) |=> (sdo == $past(link.tx_word[WORD_BITS-1])))
		else $error("first output bit is not the word MSB");
	a_rx_word_done: assert property (@(negedge sclk) disable iff (link.core_rst)
		(rcnt_ff == LAST) |=> (rword_ff == $past(nxt_rsr)) && (tgl_ff != $past(tgl_ff)))
		else $error("completed word not handed over");
	c_word_done: cover property (@(negedge sclk) disable iff (frame_clr) rcnt_ff == LAST);
endmodule : spi_shift_engine

// ==== tb/spi_host_model.sv ====
// ****************************************
// Serial controller model
// ****************************************
module spi_host_model #(
	parameter int unsigned WORD_BITS = 24
) (
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_seen;
	logic line;
	// Released line shows the inverse of its last level
	assign line = sdo_oe ? sdo : ~last_seen;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		last_seen = 1'b0;
	end
	task automatic frame(input logic [WORD_BITS-1:0] w, input int nbits, input bit done,
		output logic [WORD_BITS-1:0] got);
		got = '0;
		if (cs_n) begin
			cs_n = 1'b0;
			#20;
		end
		for (int i = 0; i < nbits; i++) begin
			sclk = 1'b1;
			sdi = w[WORD_BITS-1-i];
			#32;
			got = {got[WORD_BITS-2:0], line};
			last_seen = line;
			sclk = 1'b0;
			#32;
		end
		if (done) begin
			#16;
			cs_n = 1'b1;
			sdi = ~sdi;
		end
	endtask : frame
endmodule : spi_host_model

// ==== tb/adc_serial_port_test.sv ====
module adc_serial_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned WB = 24;
	localparam int unsigned POR = 50;
	localparam int unsigned RA = 10;
	localparam int unsigned TO = 64;
	logic clk, resetn, sclk, cs_n, sdi, sdo, sdo_oe, sync_reset_n, conv_done, tx_load;
	logic rx_valid, sync_pulse, device_reset, por_done, regs_ready, conversion_ready_strobe;
	logic [WB-1:0] tx_data, rx_data, w, h, got;
	int err_total, n_compared, cyc, hi, lo, ra_at, por_at;
	bit sync_seen, rst_seen, rx_seen;
	int lows[5] = '{3, 100, 2047, 2048, 2060};
	adc_serial_port #(.WORD_BITS(WB), .POR_CYCLES(POR), .REGACQ_CYCLES(RA),
		.TIMEOUT_CYCLES(TO)) dut_u (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .sync_reset_n(sync_reset_n),
		.conv_done(conv_done), .tx_load(tx_load), .tx_data(tx_data), .rx_data(rx_data),
		.rx_valid(rx_valid), .sync_pulse(sync_pulse), .device_reset(device_reset),
		.por_done(por_done), .regs_ready(regs_ready),
		.conversion_ready_strobe(conversion_ready_strobe));
	spi_host_model #(.WORD_BITS(WB)) host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
		.sdo_oe(sdo_oe));
	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic check(input bit ok, input string msg);
		n_compared++;
		if (!ok) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic wait_rx;
		for (int k = 0; k < 20 && !rx_seen; k++) tick(1);
	endtask : wait_rx
	function automatic bit reset_len(input int n);
		return n >= 2048;
	endfunction : reset_len
	always @(negedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("unexpected at %0t: run too long", $time);
			end_of_test();
		end
		sync_seen |= (sync_pulse === 1'b1);
		rst_seen |= (device_reset === 1'b1);
		rx_seen |= (rx_valid === 1'b1);
		if (conversion_ready_strobe === 1'b1) begin
			if (hi == 0) check(lo >= 4, "strobe low too short");
			hi++;
			lo = 0;
		end else begin
			if (hi != 0) check(hi == 4, "strobe high length");
			hi = 0;
			lo++;
		end
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		resetn = 1'b0;
		sync_reset_n = 1'b1;
		conv_done = 1'b0;
		tx_load = 1'b0;
		tx_data = 24'h00_0000;
		void'($urandom(43));
		tick(16);
		resetn = 1'b1;
		for (int k = 1; k < 200 && conversion_ready_strobe !== 1'b1; k++) begin
			tick(1);
			if (regs_ready === 1'b1 && ra_at == 0) ra_at = k;
			if (por_done === 1'b1 && por_at == 0) por_at = k;
		end
		check(ra_at inside {[RA-1:RA+5]}, "register time");
		check(por_at inside {[POR-1:POR+5]}, "power-on time");
		check(conversion_ready_strobe === 1'b1, "no first strobe");
		$display("test power_on done");
		tick(12);
		for (int k = 0; k < 2; k++) begin
			conv_done = 1'b1;
			tick(1);
			conv_done = 1'b0;
			tick(2);
		end
		tick(30);
		check(hi == 0, "strobe stuck");
		$display("test strobe done");
		for (int t = 0; t < 5; t++) begin
			w = (t == 0) ? 24'hff_ffff : (t == 1) ? 24'h00_0000 : WB'($urandom);
			h = WB'($urandom);
			tx_data = w;
			tx_load = 1'b1;
			tick(1);
			tx_load = 1'b0;
			tick(6);
			rx_seen = 0;
			host_u.frame(h, WB, 1, got);
			check(got === w, "sent word");
			wait_rx();
			check(rx_seen, "word valid missing");
			check(rx_data === h, "received word");
			tick(2);
			check(sdo_oe === 1'b0, "output still driven");
		end
		$display("test frames done");
		rx_seen = 0;
		host_u.frame(24'ha5_a5a5, 8, 0, got);
		tick(TO + 20);
		h = WB'($urandom);
		host_u.frame(h, WB, 1, got);
		wait_rx();
		check(rx_data === h, "word after idle drop");
		check(got === w, "sent word after idle drop");
		$display("test timeout done");
		tick(4);
		foreach (lows[i]) begin
			sync_seen = 0;
			rst_seen = 0;
			sync_reset_n = 1'b0;
			tick(lows[i]);
			sync_reset_n = 1'b1;
			tick(10);
			check(sync_seen == !reset_len(lows[i]), "sync pulse");
			check(rst_seen == reset_len(lows[i]), "device reset");
		end
		check(por_done === 1'b0, "power-on not restarted");
		$display("test sync_reset done");
		end_of_test();
	end
endmodule : adc_serial_port_test
